//--- core/pmf_defs.svh
// constants for the timing-message filter block
// assumes a 40 MHz system clock and a classic wishbone master
//
// Notes on behaviour
// - unicast enabled: port 319/320, non-reserved address is timing
// - unicast timing frames use ordinary lookup forwarding
// - unicast disabled: only multicast timing frames recognised
// - alternate master: same-domain sync/req go to network
// - no alternate master: same-domain dropped, others forwarded
// - priority bit selects all or event to top queue
// - follow_up reaches host only matching its sync
// - delay_resp reaches host only matching delay_req
// - peer responses reach host only matching pdelay_req
// - no best master: drop sync, follow_up, delay_req
// - domain check: host on match, else drop
// - checksum enabled: recompute when frame content changes
// - checksum disabled: write zero checksum
// - zero ipv4 checksum stays zero
// - ipv6 udp checksum always updated
// - reference domain is 8-bit, resets zero
// - timing handling only while global mode enabled
`ifndef PMF_DEFS_SVH
`define PMF_DEFS_SVH
// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define PMF_IDX_CFG1      14'h0514
`define PMF_IDX_CFG2      14'h0516
`define PMF_IDX_DOMVER    14'h0518
`define PMF_IDX_STATUS    14'h0600
// ----------------------------------------------------------------
// reset values and writable masks
// ----------------------------------------------------------------
`define PMF_CFG1_RST      16'h0039
`define PMF_CFG1_WMASK    16'h007E
`define PMF_CFG2_RST      16'h1004
`define PMF_CFG2_WMASK    16'h1FB4
`define PMF_DOMVER_RST    16'h0200
`define PMF_DOMVER_WMASK  16'h0FFF
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PMF_CFG1_MODE_EN  6
`define PMF_CFG2_UNICAST  12
`define PMF_CFG2_ALT_MST  11
`define PMF_CFG2_PRIO_ALL 10
`define PMF_CFG2_CHK_SYNC 9
`define PMF_CFG2_CHK_DLY  8
`define PMF_CFG2_CHK_PDLY 7
`define PMF_CFG2_AUTODROP 5
`define PMF_CFG2_CHK_DOM  4
`define PMF_CFG2_CSUM_EN  2
// ----------------------------------------------------------------
// message codes, ports, sizes
// ----------------------------------------------------------------
`define PMF_MT_SYNC       4'h0
`define PMF_MT_DREQ       4'h1
`define PMF_MT_PDREQ      4'h2
`define PMF_MT_PDRESP     4'h3
`define PMF_MT_FUP        4'h8
`define PMF_MT_DRESP      4'h9
`define PMF_MT_PDFUP      4'hA
`define PMF_UDP_EVENT     16'h013F
`define PMF_UDP_GENERAL   16'h0140
`define PMF_HOST_PORT     2'h2
`define PMF_NPORTS        3
`define PMF_ID_W          104
`define PMF_FIFO_DEPTH    16
`define PMF_DEC_W         8
`endif

//--- core/pmf_pkg.sv
// types shared by the timing-message filter
// assumes nothing beyond the defs header
package pmf_pkg;
  typedef enum logic [1:0] {PMF_L2, PMF_IPV4, PMF_IPV6} pmf_xport_t;
  typedef enum logic [1:0] {PMF_CS_KEEP, PMF_CS_CALC, PMF_CS_ZERO} pmf_csum_t;
endpackage

//--- core/pmf_top.sv
// decision fifo and the timing-message filter top
// assumes a parsed header descriptor per frame and a classic wishbone master
`include "pmf_defs.svh"

// ----------------------------------------------------------------
// decision fifo
// ----------------------------------------------------------------
module pmf_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rst_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o,
  output logic [$clog2(DEPTH):0] count_o
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0]  mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rd_q];
  assign count_o     = cnt_q;
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge clk_sys_i)
  begin
    if (push)
    begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= wr_q + AW'(1);
      end
      if (pop)
      begin
        rd_q <= rd_q + AW'(1);
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ----------------------------------------------------------------
// filter top
// ----------------------------------------------------------------
module pmf_top (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [15:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        msg_valid_i,
  output logic             msg_ready_o,
  input  wire logic [1:0]  msg_port_i,
  input  wire logic [3:0]  msg_type_i,
  input  wire logic [7:0]  msg_domain_i,
  input  wire logic [15:0] msg_seq_i,
  input  wire logic [79:0] msg_src_i,
  input  wire logic [15:0] msg_udp_dport_i,
  input  wire logic [1:0]  msg_xport_i,
  input  wire logic        msg_rsvd_addr_i,
  input  wire logic        msg_from_master_i,
  input  wire logic        msg_csum_zero_i,
  input  wire logic        msg_modified_i,
  input  wire logic        bmc_known_i,
  output logic             dec_valid_o,
  input  wire logic        dec_ready_i,
  output logic             dec_timing_o,
  output logic             dec_host_o,
  output logic             dec_net_o,
  output logic             dec_lookup_o,
  output logic             dec_drop_o,
  output logic             dec_hiq_o,
  output logic [1:0]       dec_csum_o
);
  logic [15:0] cfg1_q;
  logic [15:0] cfg2_q;
  logic [15:0] domver_q;
  logic [15:0] drop_cnt_q;
  logic        ack_q;
  logic [31:0] rdat_q;
  logic [13:0] idx;
  logic        wr_stb;
  logic [15:0] wmask;
  logic [15:0] wval;
  logic [4:0]  fifo_cnt;
  logic        push;
  logic        mode_en;
  logic        is_uni;
  logic        timing;
  logic        is_event;
  logic        from_host;
  logic        same_dom;
  logic        match;
  logic        chk_need;
  logic        host;
  logic        net;
  logic        drop;
  logic        hiq;
  pmf_pkg::pmf_csum_t csum;
  logic [`PMF_DEC_W-1:0] dec_in;
  logic [`PMF_DEC_W-1:0] dec_out;
  logic [`PMF_ID_W-1:0]  msg_id;
  logic [`PMF_ID_W-1:0]  id_q  [`PMF_NPORTS][3];
  logic                  idv_q [`PMF_NPORTS][3];
  logic [1:0]            kind;
  logic                  is_req;
  logic                  is_resp;

  // ----------------------------------------------------------------
  // wishbone slave, one wait state, unmapped reads return zero
  // ----------------------------------------------------------------
  assign idx    = wb_adr_i[15:2];
  assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q;
  assign wmask  = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
    end
    else
    begin
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      rdat_q <= '0;
    end
    else
    begin
      unique case (idx)
        `PMF_IDX_CFG1:   rdat_q <= {16'h0000, cfg1_q};
        `PMF_IDX_CFG2:   rdat_q <= {16'h0000, cfg2_q};
        `PMF_IDX_DOMVER: rdat_q <= {16'h0000, domver_q};
        `PMF_IDX_STATUS: rdat_q <= {drop_cnt_q, 11'h000, fifo_cnt};
        default:         rdat_q <= '0;
      endcase
    end
  end

  // reserved bits keep their reset value under any write
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] m);
    merge = (old & ~(wmask & m)) | (wb_dat_i[15:0] & wmask & m);
  endfunction

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      cfg1_q   <= `PMF_CFG1_RST;
      cfg2_q   <= `PMF_CFG2_RST;
      domver_q <= `PMF_DOMVER_RST;
    end
    else if (wr_stb)
    begin
      if (idx == `PMF_IDX_CFG1)
      begin
        cfg1_q <= merge(cfg1_q, `PMF_CFG1_WMASK);
      end
      if (idx == `PMF_IDX_CFG2)
      begin
        cfg2_q <= merge(cfg2_q, `PMF_CFG2_WMASK);
      end
      if (idx == `PMF_IDX_DOMVER)
      begin
        domver_q <= merge(domver_q, `PMF_DOMVER_WMASK);
      end
    end
  end

  // ----------------------------------------------------------------
  // classification
  // ----------------------------------------------------------------
  assign push      = msg_valid_i && msg_ready_o;
  assign mode_en   = cfg1_q[`PMF_CFG1_MODE_EN];
  assign is_event  = !msg_type_i[3];
  assign from_host = (msg_port_i == `PMF_HOST_PORT);
  assign same_dom  = (msg_domain_i == domver_q[7:0]);
  assign msg_id    = {msg_domain_i, msg_seq_i, msg_src_i};
  assign is_uni    = cfg2_q[`PMF_CFG2_UNICAST] && !msg_rsvd_addr_i
                     && (msg_udp_dport_i == `PMF_UDP_EVENT
                         || msg_udp_dport_i == `PMF_UDP_GENERAL);
  // unicast off leaves only reserved-address frames as timing
  assign timing    = mode_en && (msg_rsvd_addr_i || is_uni);

  always_comb
  begin
    kind     = 2'd0;
    is_req   = 1'b0;
    is_resp  = 1'b0;
    chk_need = 1'b0;
    unique case (msg_type_i)
      `PMF_MT_SYNC:   is_req = 1'b1;
      `PMF_MT_DREQ:
      begin
        kind   = 2'd1;
        is_req = 1'b1;
      end
      `PMF_MT_PDREQ:
      begin
        kind   = 2'd2;
        is_req = 1'b1;
      end
      `PMF_MT_FUP:
      begin
        is_resp  = 1'b1;
        chk_need = cfg2_q[`PMF_CFG2_CHK_SYNC];
      end
      `PMF_MT_DRESP:
      begin
        kind     = 2'd1;
        is_resp  = 1'b1;
        chk_need = cfg2_q[`PMF_CFG2_CHK_DLY];
      end
      `PMF_MT_PDRESP, `PMF_MT_PDFUP:
      begin
        kind     = 2'd2;
        is_resp  = 1'b1;
        chk_need = cfg2_q[`PMF_CFG2_CHK_PDLY];
      end
      default:        kind = 2'd0;
    endcase
  end

  // a port beyond the table never matches
  assign match = (msg_port_i < 2'(`PMF_NPORTS)) && idv_q[msg_port_i][kind]
                 && (id_q[msg_port_i][kind] == msg_id);

  always_comb
  begin
    host = timing && !from_host;
    net  = timing;
    drop = 1'b0;
    if (timing && !is_uni && !from_host && msg_from_master_i
        && (msg_type_i == `PMF_MT_SYNC || msg_type_i == `PMF_MT_DREQ))
    begin
      if (same_dom)
      begin
        host = 1'b0;
        net  = cfg2_q[`PMF_CFG2_ALT_MST];
      end
    end
    if (is_resp && chk_need && !match)
    begin
      host = 1'b0;
    end
    if (timing && cfg2_q[`PMF_CFG2_CHK_DOM] && !same_dom)
    begin
      drop = 1'b1;
    end
    if (timing && cfg2_q[`PMF_CFG2_AUTODROP] && !bmc_known_i
        && (msg_type_i == `PMF_MT_SYNC || msg_type_i == `PMF_MT_FUP
            || msg_type_i == `PMF_MT_DREQ))
    begin
      drop = 1'b1;
    end
    if (drop || is_uni)
    begin
      host = 1'b0;
      net  = 1'b0;
    end
  end

  assign hiq = timing && (cfg2_q[`PMF_CFG2_PRIO_ALL] || is_event);

  always_comb
  begin
    csum = pmf_pkg::PMF_CS_KEEP;
    if (timing && msg_xport_i == 2'(pmf_pkg::PMF_IPV6))
    begin
      csum = pmf_pkg::PMF_CS_CALC;
    end
    else if (timing && msg_xport_i == 2'(pmf_pkg::PMF_IPV4) && !msg_csum_zero_i)
    begin
      if (!cfg2_q[`PMF_CFG2_CSUM_EN])
      begin
        csum = pmf_pkg::PMF_CS_ZERO;
      end
      else if (msg_modified_i)
      begin
        csum = pmf_pkg::PMF_CS_CALC;
      end
    end
  end

  assign dec_in = {timing, host, net, !timing || is_uni, drop, hiq, csum};

  // ----------------------------------------------------------------
  // per-port identifier memory of the last sync and requests
  // ----------------------------------------------------------------
  for (genvar p = 0; p < `PMF_NPORTS; p++)
  begin : g_port
    always_ff @(posedge clk_sys_i)
    begin
      if (rst_i)
      begin
        idv_q[p] <= '{3{1'b0}};
      end
      else if (push && timing && is_req && msg_port_i == 2'(p))
      begin
        id_q[p][kind]  <= msg_id;
        idv_q[p][kind] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      drop_cnt_q <= '0;
    end
    else if (push && drop)
    begin
      drop_cnt_q <= drop_cnt_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // decision queue; a stalled consumer stalls the descriptor source
  // ----------------------------------------------------------------
  pmf_fifo #(
    .W     (`PMF_DEC_W),
    .DEPTH (`PMF_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_i   (clk_sys_i),
    .rst_i       (rst_i),
    .in_valid_i  (msg_valid_i),
    .in_ready_o  (msg_ready_o),
    .in_data_i   (dec_in),
    .out_valid_o (dec_valid_o),
    .out_ready_i (dec_ready_i),
    .out_data_o  (dec_out),
    .count_o     (fifo_cnt)
  );

  assign {dec_timing_o, dec_host_o, dec_net_o, dec_lookup_o,
          dec_drop_o, dec_hiq_o, dec_csum_o} = dec_out;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  a_unicast_class: assert property (push && mode_en && is_uni |-> timing && !host && !net)
    else $error("unicast timing frame not sent by lookup");
  a_unicast_off: assert property (push && !cfg2_q[`PMF_CFG2_UNICAST] && !msg_rsvd_addr_i |-> !timing)
    else $error("unicast frame recognised while disabled");
  a_mode_gate: assert property (push && !mode_en |-> dec_in == {4'h1, 4'h0})
    else $error("timing handling active with mode off");
  a_alt_master: assert property (push && timing && !is_uni && !from_host && msg_from_master_i && same_dom
    && msg_type_i == `PMF_MT_SYNC && !drop |-> !host && net == cfg2_q[`PMF_CFG2_ALT_MST])
    else $error("alternate master forwarding wrong");
  a_hiq_select: assert property (push && timing && !is_event |-> hiq == cfg2_q[`PMF_CFG2_PRIO_ALL])
    else $error("general message queue choice wrong");
  a_fup_assoc: assert property (push && timing && msg_type_i == `PMF_MT_FUP && cfg2_q[`PMF_CFG2_CHK_SYNC]
    && !match |-> !host && dec_in[6] == 1'b0)
    else $error("follow_up to host without matching sync");
  a_dly_assoc: assert property (push && msg_type_i == `PMF_MT_DRESP && cfg2_q[`PMF_CFG2_CHK_DLY] && !match
    |-> !host)
    else $error("delay_resp to host without match");
  a_pdly_assoc: assert property (push && kind == 2'd2 && is_resp && cfg2_q[`PMF_CFG2_CHK_PDLY] && !match
    |-> !host)
    else $error("peer response to host without match");
  a_bmc_drop: assert property (push && timing && cfg2_q[`PMF_CFG2_AUTODROP] && !bmc_known_i
    && msg_type_i == `PMF_MT_FUP |=> drop_cnt_q == $past(drop_cnt_q) + 16'h0001)
    else $error("follow_up kept without best master");
  a_domain_drop: assert property (push && timing && cfg2_q[`PMF_CFG2_CHK_DOM] && !same_dom
    |-> drop && !host)
    else $error("foreign domain not dropped");
  a_csum_zero: assert property (push && timing && msg_xport_i == 2'(pmf_pkg::PMF_IPV4)
    && !msg_csum_zero_i && !cfg2_q[`PMF_CFG2_CSUM_EN] |-> csum == pmf_pkg::PMF_CS_ZERO)
    else $error("checksum not zeroed");
  a_csum_keep: assert property (push && msg_xport_i == 2'(pmf_pkg::PMF_IPV4) && msg_csum_zero_i
    |-> csum == pmf_pkg::PMF_CS_KEEP)
    else $error("zero checksum altered");
  a_ipv6_calc: assert property (push && timing && msg_xport_i == 2'(pmf_pkg::PMF_IPV6)
    |-> csum == pmf_pkg::PMF_CS_CALC)
    else $error("ipv6 checksum not updated");
  a_cfg_reserved: assert property ((cfg2_q & ~`PMF_CFG2_WMASK) == 16'h0000)
    else $error("reserved config bit changed");
  a_wb_ack: assert property (wb_cyc_i && wb_stb_i && !ack_q |=> ack_q ##1 !ack_q)
    else $error("wishbone ack timing wrong");

  c_fup_match: cover property (push && msg_type_i == `PMF_MT_FUP && match && host);
  c_fifo_full: cover property (!msg_ready_o && msg_valid_i);
  c_unicast: cover property (push && is_uni);
  c_alt_master: cover property (push && net && same_dom && msg_from_master_i && cfg2_q[`PMF_CFG2_ALT_MST]);
endmodule

//--- tb/pmf_sink.sv
// decision consumer at the far side of the decision fifo
// assumes one clock shared with the filter and a stall control from the bench
module pmf_sink (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  input  wire logic       stall_i,
  input  wire logic       dec_valid_i,
  output logic            dec_ready_o,
  output logic [7:0]      pops_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] pops_q;

  // a stalling consumer lets the fifo fill up to its refusal point
  assign dec_ready_o = ~stall_i;
  assign pops_o      = pops_q;

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      pops_q <= 8'h00;
    else if (dec_valid_i && dec_ready_o)
      pops_q <= pops_q + 8'h01;
  end
endmodule

//--- tb/pmf_top_tb.sv
// self-checking bench for the timing-message filter top
// assumes the core design files and the decision sink model
`include "pmf_defs.svh"
module pmf_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_sys_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic        wb_cyc    = 1'b0;
  logic        wb_stb    = 1'b0;
  logic        wb_we     = 1'b0;
  logic [15:0] wb_adr    = 16'h0000;
  logic [3:0]  wb_sel    = 4'h0;
  logic [31:0] wb_dat    = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        msg_valid = 1'b0;
  logic        msg_ready_o;
  logic [1:0]  msg_port  = 2'h0;
  logic [3:0]  msg_type  = 4'h0;
  logic [7:0]  msg_dom   = 8'h00;
  logic [15:0] msg_seq   = 16'h0000;
  logic [15:0] msg_dport = 16'h0000;
  logic [1:0]  msg_xp    = 2'h0;
  logic        msg_rsvd  = 1'b0;
  logic        msg_mst   = 1'b0;
  logic        msg_cz    = 1'b0;
  logic        msg_mod   = 1'b0;
  logic        bmc       = 1'b1;
  logic        stall     = 1'b0;
  logic        dec_valid_o;
  logic        dec_ready;
  wire logic [7:0] dec_v;
  logic [1:0]  dec_csum_o;
  logic [7:0]  pops;
  logic [15:0] dport_v   = 16'h013F;
  logic [1:0]  xp_v      = 2'h1;
  logic        rsvd_v    = 1'b1;
  logic        mst_v     = 1'b0;
  logic        mod_v     = 1'b0;
  logic        cz_v      = 1'b0;
  logic [7:0]  cs_tab [8] = '{8'hB1, 8'hA0, 8'hB8, 8'hC1, 8'h32, 8'h22, 8'h38, 8'h51};
  int          err_total    = 0;
  int          total_checks = 0;
  int          n_sent       = 0;
  string       tname        = "init";

  initial
  begin
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  pmf_top pmf_top_inst (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .msg_valid_i(msg_valid), .msg_ready_o(msg_ready_o), .msg_port_i(msg_port), .msg_type_i(msg_type),
    .msg_domain_i(msg_dom), .msg_seq_i(msg_seq), .msg_src_i({64'h0123_4567_89AB_CDEF, msg_seq}),
    .msg_udp_dport_i(msg_dport), .msg_xport_i(msg_xp), .msg_rsvd_addr_i(msg_rsvd),
    .msg_from_master_i(msg_mst), .msg_csum_zero_i(msg_cz), .msg_modified_i(msg_mod), .bmc_known_i(bmc),
    .dec_valid_o(dec_valid_o), .dec_ready_i(dec_ready), .dec_timing_o(dec_v[7]), .dec_host_o(dec_v[6]),
    .dec_net_o(dec_v[5]), .dec_lookup_o(dec_v[4]), .dec_drop_o(dec_v[3]), .dec_hiq_o(dec_v[2]),
    .dec_csum_o(dec_csum_o)
  );
  assign dec_v[1:0] = dec_csum_o;

  pmf_sink pmf_sink_inst (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .stall_i(stall), .dec_valid_i(dec_valid_o),
    .dec_ready_o(dec_ready), .pops_o(pops)
  );

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      $display("FAIL %s expected %h seen %h", name, exp, seen);
      err_total++;
    end
  endtask

  task automatic give_verdict();
    $display("checks made %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // one classic cycle: held until ack is sampled, then released
  task automatic wb_io(input logic we, input logic [13:0] idx, input logic [15:0] wd, output logic [31:0] rd);
    int n;
    @(posedge clk_sys_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= {idx, 2'b00};
    wb_sel <= 4'h3;
    wb_dat <= {16'h0000, wd};
    n = 0;
    do begin @(posedge clk_sys_i); n++; end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (n >= 50)
      chk("wb_ack", 32'h0, 32'h1);
  endtask

  task automatic wr(input logic [13:0] idx, input logic [15:0] d);
    logic [31:0] r;
    wb_io(1'b1, idx, d, r);
  endtask

  task automatic rdm(input logic [13:0] idx, input logic [31:0] exp, input logic [31:0] m);
    logic [31:0] r;
    wb_io(1'b0, idx, 16'h0000, r);
    chk(tname, r & m, exp & m);
  endtask

  task automatic rdc(input logic [13:0] idx, input logic [31:0] exp);
    rdm(idx, exp, 32'hFFFF_FFFF);
  endtask

  task automatic send(input logic [1:0] p, input logic [3:0] t, input logic [7:0] d, input logic [15:0] s);
    int n;
    @(posedge clk_sys_i);
    msg_valid <= 1'b1;
    msg_port  <= p;
    msg_type  <= t;
    msg_dom   <= d;
    msg_seq   <= s;
    msg_dport <= dport_v;
    msg_xp    <= xp_v;
    msg_rsvd  <= rsvd_v;
    msg_mst   <= mst_v;
    msg_mod   <= mod_v;
    msg_cz    <= cz_v;
    n = 0;
    do begin @(posedge clk_sys_i); n++; end while (msg_ready_o !== 1'b1 && n < 200);
    msg_valid <= 1'b0;
    if (n >= 200)
      chk("msg_ready_wait", 32'h0, 32'h1);
    n_sent++;
  endtask

  task automatic pop(input logic [7:0] e, input logic [7:0] m);
    int n;
    n = 0;
    do begin @(posedge clk_sys_i); n++; end while (!(dec_valid_o === 1'b1 && dec_ready === 1'b1) && n < 200);
    chk("dec_valid", {31'h0, dec_valid_o}, 32'h1);
    chk(tname, {24'h0, dec_v & m}, {24'h0, e & m});
  endtask

  task automatic msg(input logic [1:0] p, input logic [3:0] t, input logic [7:0] d, input logic [15:0] s,
                     input logic [7:0] e, input logic [7:0] m);
    send(p, t, d, s);
    pop(e, m);
  endtask

  // decision byte: timing host net lookup drop hiq csum[1:0]
  initial
  begin
    repeat (12) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    tname = "reset_values";
    rdc(`PMF_IDX_CFG1, 32'h0039);
    rdc(`PMF_IDX_CFG2, 32'h1004);
    rdc(`PMF_IDX_DOMVER, 32'h0200);
    rdc(`PMF_IDX_STATUS, 32'h0000);
    wr(14'h0520, 16'hFFFF);
    rdc(14'h0520, 32'h0000);
    $display("test reset_values done");
    tname = "mode_off";
    msg(2'h0, 4'h0, 8'h00, 16'h0001, 8'h10, 8'hFF);
    wr(`PMF_IDX_CFG1, 16'h0079);
    rdc(`PMF_IDX_CFG1, 32'h0079);
    $display("test mode_off done");
    tname = "unicast";
    rsvd_v = 1'b0;
    for (int i = 0; i < 2; i++)
    begin
      dport_v = 16'h013F + 16'(i);
      msg(2'h0, 4'h0, 8'h00, 16'h0002, 8'h90, 8'hF8);
    end
    dport_v = 16'h0141;
    msg(2'h0, 4'h0, 8'h00, 16'h0002, 8'h10, 8'hF8);
    wr(`PMF_IDX_CFG2, 16'h0004);
    dport_v = 16'h013F;
    msg(2'h0, 4'h0, 8'h00, 16'h0002, 8'h10, 8'hF8);
    $display("test unicast done");
    tname = "alt_master";
    wr(`PMF_IDX_CFG2, 16'h1004);
    rsvd_v = 1'b1;
    mst_v = 1'b1;
    msg(2'h0, 4'h0, 8'h00, 16'h0003, 8'h80, 8'hE0);
    msg(2'h0, 4'h1, 8'h05, 16'h0004, 8'hE0, 8'hE0);
    wr(`PMF_IDX_CFG2, 16'h1804);
    msg(2'h0, 4'h0, 8'h00, 16'h0005, 8'hA0, 8'hE0);
    msg(2'h0, 4'h1, 8'h00, 16'h0006, 8'hA0, 8'hE0);
    mst_v = 1'b0;
    $display("test alt_master done");
    tname = "priority";
    wr(`PMF_IDX_CFG2, 16'h1004);
    msg(2'h0, 4'h0, 8'h00, 16'h0007, 8'h04, 8'h04);
    msg(2'h0, 4'h8, 8'h00, 16'h0007, 8'h00, 8'h04);
    wr(`PMF_IDX_CFG2, 16'h1404);
    msg(2'h0, 4'h8, 8'h00, 16'h0008, 8'h04, 8'h04);
    $display("test priority done");
    tname = "checksum";
    foreach (cs_tab[i])
    begin
      wr(`PMF_IDX_CFG2, cs_tab[i][7] ? 16'h1004 : 16'h1000);
      xp_v = cs_tab[i][6:5];
      mod_v = cs_tab[i][4];
      cz_v = cs_tab[i][3];
      msg(2'h0, 4'h0, 8'h00, 16'h0009, {6'h00, cs_tab[i][1:0]}, 8'h03);
    end
    xp_v = 2'h1;
    mod_v = 1'b0;
    cz_v = 1'b0;
    $display("test checksum done");
    tname = "association";
    wr(`PMF_IDX_CFG2, 16'h1204);
    msg(2'h1, 4'h0, 8'h00, 16'h0007, 8'h80, 8'h80);
    msg(2'h1, 4'h8, 8'h00, 16'h0007, 8'h40, 8'h40);
    msg(2'h1, 4'h8, 8'h00, 16'h0008, 8'h00, 8'h40);
    wr(`PMF_IDX_CFG2, 16'h1104);
    msg(2'h1, 4'h1, 8'h00, 16'h0003, 8'h80, 8'h80);
    msg(2'h1, 4'h9, 8'h00, 16'h0003, 8'h40, 8'h40);
    msg(2'h1, 4'h9, 8'h00, 16'h0004, 8'h00, 8'h40);
    wr(`PMF_IDX_CFG2, 16'h1084);
    msg(2'h0, 4'h2, 8'h00, 16'h0009, 8'h80, 8'h80);
    msg(2'h0, 4'h3, 8'h00, 16'h0009, 8'h40, 8'h40);
    msg(2'h0, 4'hA, 8'h00, 16'h0009, 8'h40, 8'h40);
    msg(2'h0, 4'h3, 8'h00, 16'h000A, 8'h00, 8'h40);
    $display("test association done");
    tname = "autodrop";
    wr(`PMF_IDX_CFG2, 16'h1024);
    bmc <= 1'b0;
    msg(2'h0, 4'h0, 8'h00, 16'h0011, 8'h08, 8'h68);
    msg(2'h0, 4'h8, 8'h00, 16'h0011, 8'h08, 8'h68);
    msg(2'h0, 4'h1, 8'h00, 16'h0012, 8'h08, 8'h68);
    msg(2'h0, 4'h2, 8'h00, 16'h0013, 8'h60, 8'h68);
    bmc <= 1'b1;
    msg(2'h0, 4'h0, 8'h00, 16'h0014, 8'h60, 8'h68);
    $display("test autodrop done");
    tname = "domain";
    wr(`PMF_IDX_DOMVER, 16'h0233);
    rdc(`PMF_IDX_DOMVER, 32'h0233);
    wr(`PMF_IDX_CFG2, 16'h1014);
    msg(2'h0, 4'h0, 8'h33, 16'h0015, 8'h40, 8'h48);
    msg(2'h0, 4'h0, 8'h34, 16'h0016, 8'h08, 8'h48);
    rdm(`PMF_IDX_STATUS, 32'h0004_0000, 32'hFFFF_0000);
    $display("test domain done");
    tname = "reserved";
    wr(`PMF_IDX_CFG2, 16'hFFFF);
    rdc(`PMF_IDX_CFG2, 32'h1FB4);
    wr(`PMF_IDX_DOMVER, 16'hFFFF);
    rdc(`PMF_IDX_DOMVER, 32'h0FFF);
    wr(`PMF_IDX_CFG1, 16'hFFFF);
    rdc(`PMF_IDX_CFG1, 32'h007F);
    $display("test reserved done");
    tname = "fifo_fill";
    wr(`PMF_IDX_CFG2, 16'h1004);
    stall <= 1'b1;
    rsvd_v = 1'b0;
    dport_v = 16'h0141;
    for (int i = 0; i < `PMF_FIFO_DEPTH; i++)
      send(2'h0, 4'h0, 8'h00, 16'(i));
    @(posedge clk_sys_i);
    chk("msg_ready", {31'h0, msg_ready_o}, 32'h0);
    rdm(`PMF_IDX_STATUS, 32'h0000_0010, 32'h0000_001F);
    stall <= 1'b0;
    for (int i = 0; i < `PMF_FIFO_DEPTH; i++)
      pop(8'h10, 8'hFF);
    @(posedge clk_sys_i);
    chk("drained", {31'h0, dec_valid_o}, 32'h0);
    chk("pops", {24'h0, pops}, 32'(n_sent[7:0]));
    $display("test fifo_fill done");
    give_verdict();
  end

  // the tests take a few hundred cycles; this span is far beyond that
  initial
  begin
    #(25 * 20000);
    err_total++;
    give_verdict();
  end
endmodule
